// *** ssq_pkg.sv ***
// ssq_pkg: register map, field positions and timing for the i2c sequencer
// assumes a 32-bit ahb-lite slave with one register per aligned word
package ssq_pkg;
  localparam logic [7:0] ADDR_CTRL1  = 8'h00;
  localparam logic [7:0] ADDR_CTRL2  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_BUF    = 8'h0c;
  localparam logic [7:0] ADDR_BRG    = 8'h10;
  localparam logic [7:0] ADDR_FLAGS  = 8'h14;

  localparam int CTRL2_ACK_SEQ_ENABLE = 4;
  localparam int CTRL2_ACK_DATA_VALUE = 5;
  localparam int CTRL2_STOP  = 2;
  localparam int STAT_STOPD  = 4;
  localparam int CTRL1_WRITE_COLLISION  = 7;
  localparam int CTRL1_OVF   = 6;
  localparam int CTRL1_EN    = 5;
  localparam int FLAG_IRQ    = 0;

  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [7:0] BRG_RESET   = 8'h31;

  typedef enum logic [1:0] {
    HTRANS_IDLE, HTRANS_BUSY, HTRANS_NONSEQ, HTRANS_SEQ
  } ssq_htrans_type;
endpackage : ssq_pkg

// *** ssq_brg.sv ***
// ssq_brg: baud-rate down counter, one-cycle pulse at terminal count
// assumes load and run come from the sequencer in the same clock domain
`timescale 1ns/1ps
module ssq_brg #(
  parameter int WIDTH = 8
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             load,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] reload,
  output logic                  tick
);
  logic [WIDTH-1:0] cnt_q;
  wire              at_zero = (cnt_q == '0);

  // tick must not look at load: load follows the state change that tick causes
  assign tick = run && at_zero;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (load || (run && at_zero)) begin
      cnt_q <= reload;
    end else if (run) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : ssq_brg

// *** ssq_top.sv ***
// ssq_top: i2c master acknowledge and stop sequencer with ahb-lite regs
// assumes scl/sda pins open drain, inputs synchronous to hclk
`timescale 1ns/1ps
module ssq_top
  import ssq_pkg::*;
#(
  parameter int BRG_WIDTH = 8
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_n,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  input  wire logic              rx_byte_valid,
  input  wire logic [7:0]        rx_byte,
  output logic                   serial_port_irq_flag
);
  import ssq_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACK_LOW, ST_ACK_HIGH, ST_STOP_SDA, ST_STOP_CNT,
    ST_STOP_SCL, ST_STOP_DET, ST_STOP_END
  } ssq_state_type;

  ////////////////////////////////////////////////////////////////////////
  // registers
  ssq_state_type    state_q, state_d;
  logic [7:0]       ctrl1_q, ctrl2_q, status_q, buf_q;
  logic [7:0]       brg_q;
  logic             buf_full_q, irq_q;
  logic             ph_valid_q, ph_write_q;
  logic [7:0]       ph_addr_q;
  logic [31:0]      rdata_q;
  logic             scl_low_q, sda_low_q;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire       ap_take   = hsel && hready && htrans[1];
  wire       wr_en     = ph_valid_q && ph_write_q;
  wire       wr_ctrl1  = wr_en && (ph_addr_q == ADDR_CTRL1);
  wire       wr_ctrl2  = wr_en && (ph_addr_q == ADDR_CTRL2);
  wire       wr_status = wr_en && (ph_addr_q == ADDR_STATUS);
  wire       wr_buf    = wr_en && (ph_addr_q == ADDR_BUF);
  wire       wr_brg    = wr_en && (ph_addr_q == ADDR_BRG);
  wire       wr_flags  = wr_en && (ph_addr_q == ADDR_FLAGS);
  wire       rd_buf    = ap_take && !hwrite && (haddr[7:0] == ADDR_BUF);
  wire       seq_busy  = (state_q != ST_IDLE);
  wire       write_collision_set  = wr_buf && seq_busy;
  wire       ovf_set   = rx_byte_valid && buf_full_q;
  wire [7:0] wd        = hwdata[7:0];
  wire       port_on   = ctrl1_q[CTRL1_EN];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // baud-rate generator
  logic brg_load, brg_run, brg_tick;
  assign brg_load = (state_q != state_d);
  assign brg_run  = (state_q == ST_ACK_LOW) || (state_q == ST_STOP_CNT)
                 || (state_q == ST_STOP_SCL) || (state_q == ST_STOP_END)
                 || ((state_q == ST_ACK_HIGH) && scl_i);

  ssq_brg #(.WIDTH(BRG_WIDTH)) u_brg (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (brg_load),
    .run     (brg_run),
    .reload  (brg_q[BRG_WIDTH-1:0]),
    .tick    (brg_tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (port_on && ctrl2_q[CTRL2_ACK_SEQ_ENABLE]) state_d = ST_ACK_LOW;
        else if (port_on && ctrl2_q[CTRL2_STOP]) state_d = ST_STOP_SDA;
      end
      ST_ACK_LOW:  if (brg_tick) state_d = ST_ACK_HIGH;
      ST_ACK_HIGH: if (brg_tick) state_d = ST_IDLE;
      ST_STOP_SDA: if (!sda_i) state_d = ST_STOP_CNT;
      ST_STOP_CNT: if (brg_tick) state_d = ST_STOP_SCL;
      ST_STOP_SCL: if (brg_tick) state_d = ST_STOP_DET;
      ST_STOP_DET: if (sda_i && scl_i) state_d = ST_STOP_END;
      ST_STOP_END: if (brg_tick) state_d = ST_IDLE;
      default:     state_d = ST_IDLE;
    endcase
    if (!port_on) state_d = ST_IDLE;
  end

  // pin drive: clock held low in idle after the ninth clock
  wire scl_low_d = port_on && (state_d == ST_IDLE || state_d == ST_ACK_LOW
                   || state_d == ST_STOP_SDA || state_d == ST_STOP_CNT);
  wire sda_low_d = port_on && ((state_d == ST_ACK_LOW
                   || state_d == ST_ACK_HIGH) ? !ctrl2_q[CTRL2_ACK_DATA_VALUE]
                   : (state_d == ST_STOP_SDA || state_d == ST_STOP_CNT
                   || state_d == ST_STOP_SCL));

  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_n = !scl_low_q;
  assign sda_oe_n = !sda_low_q;
  assign serial_port_irq_flag = irq_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= ST_IDLE;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus address phase and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q  <= 8'h00;
      rdata_q    <= 32'h0000_0000;
    end else begin
      ph_valid_q <= ap_take;
      ph_write_q <= hwrite;
      ph_addr_q  <= haddr[7:0];
      if (ap_take && !hwrite) begin
        unique case (haddr[7:0])
          ADDR_CTRL1:  rdata_q <= {24'h000000, ctrl1_q};
          ADDR_CTRL2:  rdata_q <= {24'h000000, ctrl2_q};
          ADDR_STATUS: rdata_q <= {24'h000000, status_q};
          ADDR_BUF:    rdata_q <= {24'h000000, buf_q};
          ADDR_BRG:    rdata_q <= {24'h000000, brg_q};
          ADDR_FLAGS:  rdata_q <= {31'h0, irq_q};
          default:     rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and status registers
  wire ack_done  = (state_q == ST_ACK_HIGH) && (state_d == ST_IDLE);
  wire stop_done = (state_q == ST_STOP_END) && (state_d == ST_IDLE);
  wire stop_seen = (state_q == ST_STOP_DET) && (state_d == ST_STOP_END);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_q    <= CTRL1_RESET;
      ctrl2_q    <= 8'h00;
      status_q   <= 8'h00;
      buf_q      <= 8'h00;
      brg_q      <= BRG_RESET;
      buf_full_q <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      if (wr_ctrl1) ctrl1_q <= wd;
      if (write_collision_set) ctrl1_q[CTRL1_WRITE_COLLISION] <= 1'b1;
      if (ovf_set) ctrl1_q[CTRL1_OVF] <= 1'b1;
      if (wr_ctrl2) ctrl2_q <= wd;
      if (ack_done || !port_on) ctrl2_q[CTRL2_ACK_SEQ_ENABLE] <= 1'b0;
      if (stop_done || !port_on) ctrl2_q[CTRL2_STOP] <= 1'b0;
      if (wr_status) status_q <= wd;
      if (stop_seen) status_q[STAT_STOPD] <= 1'b1;
      if (wr_buf && !seq_busy) buf_q <= wd;
      if (rx_byte_valid) buf_q <= rx_byte;
      if (rd_buf) buf_full_q <= 1'b0;
      if (rx_byte_valid) buf_full_q <= 1'b1;
      if (wr_brg) brg_q <= wd;
      if (wr_flags) irq_q <= wd[FLAG_IRQ];
      if (stop_done) irq_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_ack_scl_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_ACK_LOW) |-> scl_low_q)
    else $error("clock not held low during acknowledge");
  a_ack_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    ack_done |=> !ctrl2_q[CTRL2_ACK_SEQ_ENABLE] && state_q == ST_IDLE)
    else $error("acknowledge enable not cleared");
  a_write_collision_set: assert property (@(posedge hclk) disable iff (!hresetn)
    write_collision_set && !rx_byte_valid
    |=> ctrl1_q[CTRL1_WRITE_COLLISION] && $stable(buf_q))
    else $error("collision not flagged or buffer changed");
  a_stop_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_IDLE && port_on && ctrl2_q[CTRL2_STOP]
     && !ctrl2_q[CTRL2_ACK_SEQ_ENABLE]) |=> state_q == ST_STOP_SDA)
    else $error("stop did not start");
  a_stop_sda: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_STOP_CNT) |-> sda_low_q && scl_low_q)
    else $error("stop data not driven low");
  a_scl_release: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_STOP_SCL) |-> !scl_low_q && sda_low_q)
    else $error("stop release order wrong");
  a_stop_det: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_seen |=> status_q[STAT_STOPD])
    else $error("stop not detected");
  a_irq_set: assert property (@(posedge hclk) disable iff (!hresetn)
    stop_done |=> irq_q && !ctrl2_q[CTRL2_STOP])
    else $error("irq flag not set at stop end");
  a_ovf_set: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_set |=> ctrl1_q[CTRL1_OVF])
    else $error("overflow not flagged");
  a_idle_scl: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_IDLE && port_on && $past(port_on)) |-> scl_low_q)
    else $error("clock not held low while idle");
endmodule : ssq_top

// *** ssq_i2c_slave.sv ***
// ssq_i2c_slave: two-wire slave seen as open-drain pins with pull-ups
// assumes the sequencer splits each pin into level, enable and input
`timescale 1ns/1ps
module ssq_i2c_slave (
  input  wire logic scl_o,
  input  wire logic scl_oe_n,
  input  wire logic sda_o,
  input  wire logic sda_oe_n,
  input  wire logic stretch,
  output logic      scl_i,
  output logic      sda_i
);
  // wired-and: a released line floats to the pull-up level, except scl, which stretch holds low
  assign scl_i = scl_oe_n ? ~stretch : scl_o;
  assign sda_i = sda_oe_n ? 1'b1 : sda_o;
endmodule : ssq_i2c_slave

// *** ssq_top_bench.sv ***
// ssq_top_bench: register table loop, then ack, stop and overflow cases
// assumes ssq_pkg and ssq_top, a zero-wait single ahb-lite slave
`timescale 1ns/1ps
module ssq_top_bench;
  import ssq_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
  } ssq_row_type;
  logic        hclk, hresetn, hsel, hwrite, rx_byte_valid, stretch;
  logic        scl_i, sda_i, scl_o, sda_o, scl_oe_n, sda_oe_n;
  logic        hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  rx_byte;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          fail_count, comparisons;
  ssq_row_type rows [7] = '{
    '{ADDR_CTRL1, 1'b0, 32'h0, 32'h00}, '{ADDR_BRG, 1'b0, 32'h0, 32'h31},
    '{ADDR_CTRL2, 1'b1, 32'h0, 32'h00}, '{ADDR_STATUS, 1'b1, 32'h0, 32'h0},
    '{ADDR_CTRL1, 1'b1, 32'h20, 32'h20}, '{ADDR_BRG, 1'b1, 32'h3, 32'h3},
    '{8'h18, 1'b1, 32'hff, 32'h0}};

  ssq_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .serial_port_irq_flag(irq));
  ssq_i2c_slave slave_u (.scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .stretch(stretch),
    .scl_i(scl_i), .sda_i(sda_i));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic hang;
    fail_count++;
    $display("wrong value wait expected done seen timeout");
    give_verdict();
  endtask : hang

  task automatic check(input logic [31:0] seen, exp, input string nm);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 50) hang();
    end while (hreadyout !== 1'b1);
  endtask : wait_ready

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
  endtask : bus

  function automatic logic pin(input int s);
    return (s == 0) ? scl_oe_n : sda_oe_n;
  endfunction : pin

  task automatic wait_pin(input int s, input logic v);
    for (int n = 0; n < 200; n++) begin
      @(posedge hclk);
      if (pin(s) === v) return;
    end
    hang();
  endtask : wait_pin

  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    for (int n = 0; n < 100; n++) begin
      bus(1'b0, a, 32'h0);
      if (rd[b] === v) return;
    end
    hang();
  endtask : wait_bit

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {hsel, hwrite, rx_byte_valid, stretch} = '0;
    {htrans, hsize, rx_byte, haddr, hwdata} = '0;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    check({scl_oe_n, sda_oe_n, irq}, 3'b110, "pins in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].e, "register row");
    end
    check({hresp, scl_o, sda_o}, 3'b000, "okay and pin levels");
    $display("test registers done");
    repeat (3) @(posedge hclk);
    check(scl_oe_n, 1'b0, "enabled idle scl");
    stretch <= 1'b1;
    bus(1'b1, ADDR_CTRL2, 32'h10);
    wait_pin(1, 1'b0);
    bus(1'b1, ADDR_BUF, 32'ha5);
    bus(1'b0, ADDR_CTRL1, 32'h0);
    check(rd[7], 1'b1, "collision in ack");
    wait_pin(0, 1'b1);
    repeat (20) @(posedge hclk);
    bus(1'b0, ADDR_CTRL2, 32'h0);
    check(rd[4], 1'b1, "ack held by stretch");
    stretch <= 1'b0;
    wait_pin(0, 1'b0);
    wait_bit(ADDR_CTRL2, 4, 1'b0);
    bus(1'b1, ADDR_CTRL1, 32'h20);
    bus(1'b1, ADDR_CTRL2, 32'h30);
    repeat (3) @(posedge hclk);
    check(sda_oe_n, 1'b1, "not-ack level");
    wait_bit(ADDR_CTRL2, 4, 1'b0);
    $display("test acknowledge done");
    rx_byte_valid <= 1'b1;
    rx_byte <= 8'h11;
    @(posedge hclk);
    rx_byte <= 8'h22;
    @(posedge hclk);
    rx_byte_valid <= 1'b0;
    bus(1'b1, ADDR_CTRL2, 32'h04);
    wait_pin(1, 1'b0);
    bus(1'b1, ADDR_BUF, 32'h5a);
    bus(1'b0, ADDR_CTRL1, 32'h0);
    check(rd[7:6], 2'b11, "collision and overflow");
    wait_pin(0, 1'b1);
    wait_pin(1, 1'b1);
    wait_bit(ADDR_STATUS, STAT_STOPD, 1'b1);
    wait_bit(ADDR_CTRL2, CTRL2_STOP, 1'b0);
    check(irq, 1'b1, "irq after stop");
    bus(1'b0, ADDR_BUF, 32'h0);
    check(rd, 32'h22, "buffer kept");
    bus(1'b0, ADDR_CTRL1, 32'h0);
    check(rd[6], 1'b1, "overflow sticky");
    $display("test stop and overflow done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, ADDR_CTRL1, 32'h0);
    check(rd, 32'h0, "ctrl1 after reset");
    $display("test second reset done");
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    hang();
  end
endmodule : ssq_top_bench
